// ---- tws_pkg.sv ----
/*
 * Shared constants and types of the three-wire serial memory access block.
 * Assumes a 100 MHz system clock; all pin timing is resolved by sampling.
 */
package tws_pkg;

	// Clock and self-timed write
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned WRITE_TIME_MS = 10;
	localparam int unsigned WRITE_CYCLES  = WRITE_TIME_MS * 1000 * CLK_MHZ;

	// Array geometry
	localparam int unsigned MEM_BYTES_4K = 512;
	localparam int unsigned MEM_BYTES_2K = 256;
	localparam logic [4:0]  AW_X8        = 5'h09;
	localparam logic [4:0]  AW_X16       = 5'h08;
	localparam logic [4:0]  DW_X8        = 5'h08;
	localparam logic [4:0]  DW_X16       = 5'h10;
	localparam logic        STRAP_X16    = 1'b1;

	// Instruction coding
	localparam logic       LEAD_MARKER = 1'b1;
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] SPC_LOCK    = 2'h0;
	localparam logic [1:0] SPC_FILL    = 2'h1;
	localparam logic [1:0] SPC_CLEAR   = 2'h2;
	localparam logic [1:0] SPC_UNLOCK  = 2'h3;
	localparam logic [15:0] ERASED_WORD = 16'hffff;

	// Program queue entry layout
	localparam int unsigned FIFO_DEPTH   = 16;
	localparam int unsigned ENT_W        = 27;
	localparam int unsigned ENT_DATA_LSB = 0;
	localparam int unsigned ENT_ADDR_LSB = 16;
	localparam int unsigned ENT_BULK_BIT = 25;
	localparam int unsigned ENT_ORG_BIT  = 26;

	// Synchroniser lanes
	localparam int unsigned SYN_CS  = 0;
	localparam int unsigned SYN_SK  = 1;
	localparam int unsigned SYN_DI  = 2;
	localparam int unsigned SYN_ORG = 3;
	localparam int unsigned SYN_W   = 4;

	typedef enum logic [2:0] {
		DEC_IDLE,
		DEC_OPC,
		DEC_ADDR,
		DEC_DATA,
		DEC_READ,
		DEC_WAIT
	} tws_dec_e;

	typedef enum logic {
		ENG_IDLE,
		ENG_RUN
	} tws_eng_e;

endpackage

// ---- tws_sync.sv ----
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to sys_clk_i.
 */
`timescale 1ns/1ns
module tws_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	import tws_pkg::*;

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = pin_i;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_o = sync_ff;
endmodule

// ---- tws_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/1ns
module tws_fifo #(
	parameter int unsigned WIDTH = tws_pkg::ENT_W,
	parameter int unsigned DEPTH = tws_pkg::FIFO_DEPTH
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	import tws_pkg::*;

	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_ff [DEPTH];
	logic [PW:0]      wr_ff;
	logic [PW:0]      rd_ff;
	logic [PW:0]      nxt_wr;
	logic [PW:0]      nxt_rd;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	always_comb begin
		empty  = (wr_ff == rd_ff);
		full   = (wr_ff[PW-1:0] == rd_ff[PW-1:0]) && (wr_ff[PW] != rd_ff[PW]);
		push   = in_valid_i && !full;
		pop    = out_ready_i && !empty;
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			store_ff[wr_ff[PW-1:0]] <= in_data_i;
		end
	end

	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = store_ff[rd_ff[PW-1:0]];
endmodule

// ---- tws_eeprom.sv ----
/*
 * Three-wire serial memory access logic: pin decoder, read shifter,
 * program queue and self-timed write engine over a byte array.
 * Assumes host pins arrive asynchronously; the output pin is driven
 * through serial_out_pin_o / serial_out_oe_o by an outside pad.
 */
//
// Notes on behaviour
// - Array holds 2048 or 4096 bits, as 16-bit or 8-bit words.
// - Strap high selects 16-bit words, low selects 8-bit; fields follow.
// - Strap is synchronised and sampled at each marker bit; reset selects 16-bit words.
// - Serial activity only while device select is high.
// - Read instruction plus address shifts stored word out on serial output.
// - Writes are self-timed and overwrite directly, no erase first.
// - Every write cycle completes within 10 ms.
// - Program instructions only act while programming is unlocked.
// - Select reasserted after write start shows ready/busy on output.
// - Select rise, marker one, two-bit opcode, then address, in order.
// - Opcodes 10 read, 01 write, 11 erase; 00 uses top address bits.
`timescale 1ns/1ns
module tws_eeprom #(
	parameter bit          BIG_ARRAY    = 1'b1,
	parameter int unsigned WRITE_CYCLES = tws_pkg::WRITE_CYCLES,
	parameter int unsigned QUEUE_DEPTH  = tws_pkg::FIFO_DEPTH
) (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic cs_pin_i,
	input  wire logic serial_shift_clock_i,
	input  wire logic serial_in_pin_i,
	input  wire logic word_width_strap_i,
	output logic      serial_out_pin_o,
	output logic      serial_out_oe_o,
	output logic      write_busy_o
);
	import tws_pkg::*;

	localparam int unsigned MEM_BYTES = BIG_ARRAY ? MEM_BYTES_4K : MEM_BYTES_2K;
	localparam logic [9:0]  BYTE_MASK = 10'(MEM_BYTES - 1);
	localparam int unsigned TW        = $clog2(WRITE_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [SYN_W-1:0] syn;
	logic             cs_s;
	logic             sk_s;
	logic             di_s;
	logic             org_s;
	logic             sk_prev_ff;
	logic             cs_prev_ff;
	logic             sk_rise;
	logic             cs_fall;

	tws_sync #(
		.W (SYN_W)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.pin_i     ({word_width_strap_i, serial_in_pin_i, serial_shift_clock_i, cs_pin_i}),
		.sync_o    (syn)
	);

	always_comb begin
		cs_s    = syn[SYN_CS];
		sk_s    = syn[SYN_SK];
		di_s    = syn[SYN_DI];
		org_s   = syn[SYN_ORG];
		sk_rise = cs_s && sk_s && !sk_prev_ff;
		cs_fall = cs_prev_ff && !cs_s;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sk_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b0;
		end else begin
			sk_prev_ff <= sk_s;
			cs_prev_ff <= cs_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Array

	logic [7:0]       mem_ff [MEM_BYTES];
	logic             mem_we;
	logic [9:0]       idx_ff;
	logic [7:0]       mem_byte;

	function automatic logic [15:0] word_at(input logic word_width_strap, input logic [8:0] a);
		logic [9:0] b;
		b = (word_width_strap ? {a, 1'b0} : {1'b0, a}) & BYTE_MASK;
		if (word_width_strap) begin
			word_at = {mem_ff[b[8:0]], mem_ff[b[8:0] | 9'h001]};
		end else begin
			word_at = {mem_ff[b[8:0]], 8'h00};
		end
	endfunction

	always_ff @(posedge sys_clk_i) begin
		if (mem_we) begin
			mem_ff[idx_ff[8:0]] <= mem_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program queue

	logic             push_valid;
	logic             push_ready;
	logic [ENT_W-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [ENT_W-1:0] pop_data;

	tws_fifo #(
		.WIDTH (ENT_W),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.sys_clk_i   (sys_clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (push_data),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (pop_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Instruction decoder

	tws_dec_e    state_ff, nxt_state;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic [1:0]  opc_ff, nxt_opc;
	logic [8:0]  addr_ff, nxt_addr;
	logic [15:0] data_ff, nxt_data;
	logic        org_ff, nxt_org;
	logic        pend_ff, nxt_pend;
	logic        bulk_ff, nxt_bulk;
	logic        enable_ff, nxt_enable;
	logic        arm_ff, nxt_arm;
	logic [15:0] rd_sr_ff, nxt_rd_sr;
	logic        dout_ff, nxt_dout;
	logic        doe_ff, nxt_doe;
	logic [4:0]  aw;
	logic [4:0]  dw;
	logic [8:0]  addr_full;
	logic [1:0]  top2;
	logic        busy;

	always_comb begin
		aw         = (org_ff == STRAP_X16) ? AW_X16 : AW_X8;
		dw         = (org_ff == STRAP_X16) ? DW_X16 : DW_X8;
		addr_full  = {addr_ff[7:0], di_s};
		top2       = (org_ff == STRAP_X16) ? addr_full[7:6] : addr_full[8:7];
		push_valid = cs_fall && (state_ff == DEC_WAIT) && pend_ff && enable_ff;
		push_data  = {org_ff, bulk_ff, addr_ff, data_ff};
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_opc    = opc_ff;
		nxt_addr   = addr_ff;
		nxt_data   = data_ff;
		nxt_org    = org_ff;
		nxt_pend   = pend_ff;
		nxt_bulk   = bulk_ff;
		nxt_enable = enable_ff;
		nxt_arm    = arm_ff || (push_valid && push_ready);
		nxt_rd_sr  = rd_sr_ff;
		nxt_dout   = dout_ff;
		if (!cs_s) begin
			nxt_state = DEC_IDLE;
			nxt_pend  = 1'b0;
			nxt_dout  = 1'b0;
		end else if (sk_rise) begin
			case (state_ff)
				DEC_IDLE: begin
					if (di_s == LEAD_MARKER) begin
						nxt_state = DEC_OPC;
						nxt_cnt   = 5'h00;
						nxt_org   = org_s;
						nxt_arm   = 1'b0;
						nxt_addr  = 9'h000;
					end
				end
				DEC_OPC: begin
					nxt_opc = {opc_ff[0], di_s};
					if (cnt_ff == 5'h01) begin
						nxt_state = DEC_ADDR;
						nxt_cnt   = 5'h00;
					end else begin
						nxt_cnt = cnt_ff + 5'h01;
					end
				end
				DEC_ADDR: begin
					nxt_addr = addr_full;
					nxt_cnt  = cnt_ff + 5'h01;
					if (cnt_ff == aw - 5'h01) begin
						nxt_cnt   = 5'h00;
						nxt_state = DEC_WAIT;
						nxt_bulk  = 1'b0;
						nxt_data  = ERASED_WORD;
						case (opc_ff)
							OPC_READ: begin
								nxt_state = DEC_READ;
								nxt_rd_sr = word_at(org_ff, addr_full);
								nxt_dout  = 1'b0;
							end
							OPC_WRITE: begin
								nxt_state = DEC_DATA;
							end
							OPC_ERASE: begin
								nxt_pend = 1'b1;
							end
							default: begin
								case (top2)
									SPC_UNLOCK: nxt_enable = 1'b1;
									SPC_LOCK:   nxt_enable = 1'b0;
									SPC_CLEAR: begin
										nxt_pend = 1'b1;
										nxt_bulk = 1'b1;
									end
									default: begin
										nxt_bulk  = 1'b1;
										nxt_state = DEC_DATA;
									end
								endcase
							end
						endcase
					end
				end
				DEC_DATA: begin
					nxt_data = {data_ff[14:0], di_s};
					nxt_cnt  = cnt_ff + 5'h01;
					if (cnt_ff == dw - 5'h01) begin
						nxt_state = DEC_WAIT;
						nxt_pend  = 1'b1;
					end
				end
				DEC_READ: begin
					nxt_dout = rd_sr_ff[15];
					if (cnt_ff == dw - 5'h01) begin
						nxt_cnt   = 5'h00;
						nxt_addr  = addr_ff + 9'h001;
						nxt_rd_sr = word_at(org_ff, addr_ff + 9'h001);
					end else begin
						nxt_cnt   = cnt_ff + 5'h01;
						nxt_rd_sr = {rd_sr_ff[14:0], 1'b0};
					end
				end
				default: begin
					nxt_state = state_ff;
				end
			endcase
		end
		if (cs_s && (nxt_state == DEC_IDLE) && nxt_arm) begin
			nxt_dout = !busy;
		end
		nxt_doe = cs_s && ((nxt_state == DEC_READ) || ((nxt_state == DEC_IDLE) && nxt_arm));
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff  <= DEC_IDLE;
			cnt_ff    <= 5'h00;
			opc_ff    <= 2'h0;
			addr_ff   <= 9'h000;
			data_ff   <= 16'h0000;
			org_ff    <= STRAP_X16;
			pend_ff   <= 1'b0;
			bulk_ff   <= 1'b0;
			enable_ff <= 1'b0;
			arm_ff    <= 1'b0;
			rd_sr_ff  <= 16'h0000;
			dout_ff   <= 1'b0;
			doe_ff    <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			opc_ff    <= nxt_opc;
			addr_ff   <= nxt_addr;
			data_ff   <= nxt_data;
			org_ff    <= nxt_org;
			pend_ff   <= nxt_pend;
			bulk_ff   <= nxt_bulk;
			enable_ff <= nxt_enable;
			arm_ff    <= nxt_arm;
			rd_sr_ff  <= nxt_rd_sr;
			dout_ff   <= nxt_dout;
			doe_ff    <= nxt_doe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Self-timed write engine

	tws_eng_e        eng_ff, nxt_eng;
	logic [9:0]      nxt_idx;
	logic [9:0]      end_ff, nxt_end;
	logic [15:0]     edata_ff, nxt_edata;
	logic            eorg_ff, nxt_eorg;
	logic            swept_ff, nxt_swept;
	logic [TW-1:0]   timer_ff, nxt_timer;
	logic [9:0]      base;

	always_comb begin
		base      = pop_data[ENT_ORG_BIT] ?
			{pop_data[ENT_ADDR_LSB +: 9], 1'b0} : {1'b0, pop_data[ENT_ADDR_LSB +: 9]};
		base      = base & BYTE_MASK;
		pop_ready = (eng_ff == ENG_IDLE);
		mem_we    = (eng_ff == ENG_RUN) && !swept_ff;
		mem_byte  = (eorg_ff && !idx_ff[0]) ? edata_ff[15:8] : edata_ff[7:0];
		busy      = (eng_ff == ENG_RUN) || pop_valid;
		nxt_eng   = eng_ff;
		nxt_idx   = idx_ff;
		nxt_end   = end_ff;
		nxt_edata = edata_ff;
		nxt_eorg  = eorg_ff;
		nxt_swept = swept_ff;
		nxt_timer = timer_ff;
		case (eng_ff)
			ENG_IDLE: begin
				if (pop_valid) begin
					nxt_eng   = ENG_RUN;
					nxt_eorg  = pop_data[ENT_ORG_BIT];
					nxt_edata = pop_data[ENT_DATA_LSB +: 16];
					nxt_swept = 1'b0;
					nxt_timer = '0;
					if (pop_data[ENT_BULK_BIT]) begin
						nxt_idx = 10'h000;
						nxt_end = BYTE_MASK;
					end else begin
						nxt_idx = base;
						nxt_end = pop_data[ENT_ORG_BIT] ? (base | 10'h001) : base;
					end
				end
			end
			ENG_RUN: begin
				if (!swept_ff) begin
					if (idx_ff == end_ff) begin
						nxt_swept = 1'b1;
					end else begin
						nxt_idx = idx_ff + 10'h001;
					end
				end
				nxt_timer = timer_ff + 1'b1;
				if ((timer_ff >= TW'(WRITE_CYCLES - 1)) && swept_ff) begin
					nxt_eng = ENG_IDLE;
				end
			end
			default: begin
				nxt_eng = ENG_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eng_ff   <= ENG_IDLE;
			idx_ff   <= 10'h000;
			end_ff   <= 10'h000;
			edata_ff <= 16'h0000;
			eorg_ff  <= 1'b0;
			swept_ff <= 1'b0;
			timer_ff <= '0;
		end else begin
			eng_ff   <= nxt_eng;
			idx_ff   <= nxt_idx;
			end_ff   <= nxt_end;
			edata_ff <= nxt_edata;
			eorg_ff  <= nxt_eorg;
			swept_ff <= nxt_swept;
			timer_ff <= nxt_timer;
		end
	end

	assign serial_out_pin_o = dout_ff;
	assign serial_out_oe_o  = doe_ff;
	assign write_busy_o     = busy;
endmodule

// ---- tws_eeprom_properties.sv ----
/*
 * Port checker of the serial memory access block, bound to tws_eeprom.
 * Assumes only the top-level ports of tws_eeprom are visible.
 */
`timescale 1ns/1ns
module tws_eeprom_properties #(
	parameter bit          BIG_ARRAY    = 1'b1,
	parameter int unsigned WRITE_CYCLES = tws_pkg::WRITE_CYCLES,
	parameter int unsigned QUEUE_DEPTH  = tws_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic cs_pin_i,
	input wire logic serial_shift_clock_i,
	input wire logic serial_in_pin_i,
	input wire logic word_width_strap_i,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_oe_o,
	input wire logic write_busy_o
);
	localparam int unsigned BUSY_MAX = (QUEUE_DEPTH + 2) * (WRITE_CYCLES + 520);
	int unsigned cs_low_ff;
	int unsigned sk_idle_ff;
	int unsigned busy_len_ff;
	int unsigned nxt_cs_low;
	int unsigned nxt_sk_idle;
	int unsigned nxt_busy_len;
	logic        sk_prev_ff;

	////////////////////////////////////////
	// Run lengths of select low, shift clock quiet, busy high
	always_comb begin
		nxt_cs_low   = cs_pin_i ? 0 : cs_low_ff + 1;
		nxt_sk_idle  = (serial_shift_clock_i != sk_prev_ff) ? 0 : sk_idle_ff + 1;
		nxt_busy_len = write_busy_o ? busy_len_ff + 1 : 0;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_low_ff   <= 0;
			sk_idle_ff  <= 0;
			busy_len_ff <= 0;
			sk_prev_ff  <= 1'b0;
		end else begin
			cs_low_ff   <= nxt_cs_low;
			sk_idle_ff  <= nxt_sk_idle;
			busy_len_ff <= nxt_busy_len;
			sk_prev_ff  <= serial_shift_clock_i;
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence cs_gone_s;
		!cs_pin_i [*5];
	endsequence

	sequence status_up_s;
		$rose(serial_out_pin_o) && serial_out_oe_o && sk_idle_ff > 8;
	endsequence

	oe_release_a: assert property (cs_gone_s |-> !serial_out_oe_o)
		else $error("output driven with select low");
	oe_select_a: assert property ($rose(serial_out_oe_o) |-> cs_low_ff < 4)
		else $error("output enabled without select");
	reset_quiet_a: assert property ($rose(rstn_i) |-> !serial_out_oe_o && !write_busy_o)
		else $error("outputs active after reset");
	busy_start_a: assert property ($rose(write_busy_o) |-> !cs_pin_i && !$past(cs_pin_i, 2))
		else $error("write started with select high");
	busy_min_a: assert property ($fell(write_busy_o) |-> busy_len_ff >= WRITE_CYCLES)
		else $error("write cycle too short");
	busy_bound_a: assert property (busy_len_ff <= BUSY_MAX)
		else $error("write cycle too long");
	status_ready_a: assert property (status_up_s |-> !write_busy_o)
		else $error("ready shown while busy");
	out_hold_a: assert property ($changed(serial_out_pin_o) && $past(serial_out_oe_o)
		&& serial_out_oe_o |-> (sk_idle_ff < 8 || !write_busy_o))
		else $error("output moved without shift clock");
endmodule

bind tws_eeprom tws_eeprom_properties #(
	.BIG_ARRAY   (BIG_ARRAY),
	.WRITE_CYCLES(WRITE_CYCLES),
	.QUEUE_DEPTH (QUEUE_DEPTH)
) u_props (
	.sys_clk_i,
	.rstn_i,
	.cs_pin_i,
	.serial_shift_clock_i,
	.serial_in_pin_i,
	.word_width_strap_i,
	.serial_out_pin_o,
	.serial_out_oe_o,
	.write_busy_o
);

// ---- tws_host_model.sv ----
/*
 * Host controller model driving select, shift clock and serial input.
 * Assumes the serial output arrives already resolved from its enable.
 */
`timescale 1ns/1ns
module tws_host_model (
	input  wire logic sys_clk_i,
	input  wire logic serial_out_pin_i,
	output logic      cs_pin_o,
	output logic      serial_shift_clock_o,
	output logic      serial_in_pin_o
);
	int half_cycles = 25;

	initial begin
		cs_pin_o             = 1'b0;
		serial_shift_clock_o = 1'b0;
		serial_in_pin_o      = 1'b0;
	end

	task automatic gap();
		repeat (half_cycles) @(negedge sys_clk_i);
	endtask

	// Select change, data line moved off its last value
	task automatic select(input logic lvl);
		gap();
		cs_pin_o        = lvl;
		serial_in_pin_o = ~serial_in_pin_o;
		gap();
	endtask

	// Half periods of 25 cycles or more
	task automatic pulse(input logic bit_in, output logic bit_out);
		serial_in_pin_o = bit_in;
		gap();
		serial_shift_clock_o = 1'b1;
		gap();
		bit_out              = serial_out_pin_i;
		serial_shift_clock_o = 1'b0;
	endtask

	// Marker, opcode, every address bit, then data
	task automatic frame(input logic [1:0] op, input logic [8:0] adr, input int aw,
		input logic [31:0] dat, input int dw, output logic [32:0] q);
		logic b;
		select(1'b1);
		pulse(tws_pkg::LEAD_MARKER, b);
		for (int i = 1; i >= 0; i--) pulse(op[i], b);
		for (int i = aw - 1; i >= 0; i--) pulse(adr[i], b);
		q = {32'h0, b};
		for (int i = dw - 1; i >= 0; i--) begin
			pulse(dat[i], b);
			q = {q[31:0], b};
		end
		select(1'b0);
	endtask
endmodule

// ---- tb_three_wire_serial_eeprom_access.sv ----
/*
 * Self-checking testbench of the serial memory access block.
 * Assumes tws_host_model drives the pins; the output pad is resolved here.
 */
`timescale 1ns/1ns
module tb_three_wire_serial_eeprom_access;
	import tws_pkg::*;
	localparam int unsigned WC = 4000;
	logic        sys_clk_i          = 1'b0;
	logic        rstn_i             = 1'b0;
	logic        word_width_strap_i = 1'b1;
	wire         cs_pin_i;
	wire         serial_shift_clock_i;
	wire         serial_in_pin_i;
	wire         do_line;
	logic        serial_out_pin_o;
	logic        serial_out_oe_o;
	logic        write_busy_o;
	int          miscompares = 0;
	int          tests_run   = 0;
	int          cycles      = 0;
	int          aw          = 8;
	logic [32:0] q;

	////////////////////////////////////////
	always #5 sys_clk_i = ~sys_clk_i;
	assign do_line = serial_out_oe_o ? serial_out_pin_o : 1'bz;

	tws_eeprom #(.WRITE_CYCLES(WC)) u_dut (
		.sys_clk_i,
		.rstn_i,
		.cs_pin_i,
		.serial_shift_clock_i,
		.serial_in_pin_i,
		.word_width_strap_i,
		.serial_out_pin_o,
		.serial_out_oe_o,
		.write_busy_o
	);

	tws_host_model u_host (
		.sys_clk_i           (sys_clk_i),
		.serial_out_pin_i    (do_line),
		.cs_pin_o            (cs_pin_i),
		.serial_shift_clock_o(serial_shift_clock_i),
		.serial_in_pin_o     (serial_in_pin_i)
	);

	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [8:0] spc(input logic [1:0] code);
		return {code, 7'h0} >> (9 - aw);
	endfunction

	task automatic send(input logic [1:0] op, input logic [8:0] adr, input logic [31:0] dat,
		input int n);
		u_host.frame(op, adr, aw, dat, n, q);
	endtask

	task automatic prog(input logic [1:0] op, input logic [8:0] adr, input logic [31:0] dat,
		input int n);
		int k;
		k = 0;
		send(op, adr, dat, n);
		check("busy", 1, write_busy_o);
		u_host.select(1'b1);
		check("status oe", 1, serial_out_oe_o);
		check("status busy", 0, do_line);
		while (write_busy_o === 1'b1 && k < WC + 600) begin
			@(negedge sys_clk_i);
			k++;
		end
		check("write done", 0, write_busy_o);
		repeat (8) @(negedge sys_clk_i);
		check("status ready", 1, do_line);
		u_host.select(1'b0);
	endtask

	////////////////////////////////////////
	task automatic t_write_read();
		logic b;
		send(OPC_SPECIAL, spc(SPC_UNLOCK), 0, 0);
		prog(OPC_WRITE, 9'h12, 32'ha5c3, 16);
		prog(OPC_WRITE, 9'h13, 32'h0f1e, 16);
		send(OPC_READ, 9'h12, 0, 32);
		check("seq read", 32'ha5c30f1e, q[31:0]);
		check("dummy", 0, q[32]);
		prog(OPC_WRITE, 9'h12, 32'h5a3c, 16);
		send(OPC_READ, 9'h12, 0, 16);
		check("overwrite", 32'h5a3c, q[31:0]);
		u_host.select(1'b1);
		u_host.pulse(1'b1, b);
		u_host.pulse(1'b0, b);
		u_host.pulse(1'b1, b);
		u_host.select(1'b0);
		check("abort busy", 0, write_busy_o);
		check("abort oe", 0, serial_out_oe_o);
	endtask

	task automatic t_x8();
		word_width_strap_i = 1'b0;
		aw                 = 9;
		u_host.half_cycles = 40;
		prog(OPC_WRITE, 9'h1ff, 32'h3c, 8);
		send(OPC_READ, 9'h1ff, 0, 8);
		check("x8 read", 32'h3c, q[31:0]);
		word_width_strap_i = 1'b1;
		aw                 = 8;
		u_host.half_cycles = 25;
		send(OPC_READ, 9'h0ff, 0, 16);
		check("pairing", 32'h3c, {24'h0, q[7:0]});
	endtask

	task automatic t_erase_bulk();
		prog(OPC_ERASE, 9'h12, 0, 0);
		send(OPC_READ, 9'h12, 0, 16);
		check("erase", ERASED_WORD, q[31:0]);
		prog(OPC_SPECIAL, spc(SPC_FILL), 32'h1234, 16);
		send(OPC_READ, 9'h40, 0, 16);
		check("fill", 32'h1234, q[31:0]);
		prog(OPC_SPECIAL, spc(SPC_CLEAR), 0, 0);
		send(OPC_SPECIAL, spc(SPC_LOCK), 0, 0);
		send(OPC_WRITE, 9'h40, 32'h0, 16);
		check("lock busy", 0, write_busy_o);
		send(OPC_READ, 9'h40, 0, 16);
		check("lock data", ERASED_WORD, q[31:0]);
	endtask

	task automatic t_fill();
		send(OPC_SPECIAL, spc(SPC_UNLOCK), 0, 0);
		for (int i = 0; i < 20; i++) send(OPC_ERASE, 9'(i), 0, 0);
		check("queue busy", 1, write_busy_o);
		rstn_i = 1'b0;
		repeat (5) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		check("reset oe", 0, serial_out_oe_o);
		check("reset busy", 0, write_busy_o);
		send(OPC_WRITE, 9'h05, 32'h0001, 16);
		check("reset lock", 0, write_busy_o);
	endtask

	task automatic t_locked();
		check("idle oe", 0, serial_out_oe_o);
		send(OPC_WRITE, 9'h03, 32'h1111, 16);
		check("locked busy", 0, write_busy_o);
	endtask

	////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 100000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		repeat (5) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		t_locked();
		t_write_read();
		t_x8();
		t_erase_bulk();
		t_fill();
		test_done();
	end
endmodule
